// file: hw/monitor_converter_consts.svh
// Constants for the monitor converter control block
`ifndef MABS_CONSTS_SVH
`define MABS_CONSTS_SVH
`define MABS_MCLK_HZ        40000000
`define MABS_CONV_CLK_HZ    200000
`define MABS_DIV_COUNT      (`MABS_MCLK_HZ / `MABS_CONV_CLK_HZ)
`define MABS_RES_BITS       10
`define MABS_CONV_PERIODS   13
`define MABS_WAKE_PERIODS   2
`define MABS_CH_BUTTON      1'h0
`define MABS_CH_VSENSE      1'h1
`define MABS_RESULT_RESET   10'h000
`endif

// file: hw/monitor_converter_pkg.sv
// Types for the monitor converter control block
package mabs_pkg;
  typedef enum logic [2:0] {
    MABS_ST_OFF   = 3'h0,
    MABS_ST_WAKE  = 3'h1,
    MABS_ST_SAMP  = 3'h2,
    MABS_ST_BITS  = 3'h3,
    MABS_ST_DONE  = 3'h4
  } mabs_state_t;
endpackage : mabs_pkg

// file: hw/monitor_converter_tick_div.sv
// Divider making the converter clock enable from the system clock
`timescale 1ns/10ps
`include "monitor_converter_consts.svh"
module mabs_tick_div #(
  parameter int DIV = `MABS_DIV_COUNT
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  // Enable
  input  wire logic run_in,
  output logic      tick_out
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run_in) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg  <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_out <= tick_next;
    end
  end
endmodule : mabs_tick_div

// file: hw/monitor_converter_ctrl.sv
// Monitor converter control: mode sequencing, SAR register and result hold
`timescale 1ns/10ps
`include "monitor_converter_consts.svh"
module mabs_ctrl #(
  parameter int RES_BITS = `MABS_RES_BITS,
  parameter int CONV_PER = `MABS_CONV_PERIODS
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                reset_n_in,
  // Control
  input  wire logic                enable_in,
  input  wire logic                continuous_in,
  input  wire logic                vsense_sel_in,
  input  wire logic                start_in,
  // Analog side
  input  wire logic                button_cmp_in,
  input  wire logic                sar_cmp_in,
  output logic                     pwr_en_out,
  output logic                     conv_clk_en_out,
  output logic                     chan_sel_out,
  output logic [RES_BITS-1:0]      dac_code_out,
  // Results
  output logic [RES_BITS-1:0]      result_out,
  output logic                     result_chan_out,
  output logic                     done_out,
  output logic                     busy_out
);
  // Synchronisers for the two comparator pins
  logic                  btn_s1_reg;
  logic                  btn_s2_reg;
  logic                  btn_s3_reg;
  logic                  sar_s1_reg;
  logic                  sar_s2_reg;
  logic                  press;
  // Converter clock enable
  logic                  tick;
  // Sequencer state
  mabs_pkg::mabs_state_t state_reg;
  mabs_pkg::mabs_state_t state_next;
  logic [3:0]            per_reg;
  logic [3:0]            per_next;
  logic [RES_BITS-1:0]   sar_reg;
  logic [RES_BITS-1:0]   sar_next;
  logic [RES_BITS-1:0]   result_next;
  logic                  chan_next;
  logic                  rchan_next;
  logic                  done_next;
  logic                  pend_reg;
  logic                  pend_next;
  // Checking helper: cycles since the last converter tick
  logic [15:0]           gap_reg;
  logic [15:0]           gap_next;
  logic                  gap_ok_reg;
  logic                  gap_ok_next;

  // Pins from the analog domain pass two flip-flops
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      btn_s1_reg <= 1'b0;
      btn_s2_reg <= 1'b0;
      btn_s3_reg <= 1'b0;
      sar_s1_reg <= 1'b0;
      sar_s2_reg <= 1'b0;
    end else begin
      btn_s1_reg <= button_cmp_in;
      btn_s2_reg <= btn_s1_reg;
      btn_s3_reg <= btn_s2_reg;
      sar_s1_reg <= sar_cmp_in;
      sar_s2_reg <= sar_s1_reg;
    end
  end

  // Rising edge of the synchronised press comparator
  assign press = btn_s2_reg & ~btn_s3_reg;

  // 200 kHz converter clock enable from the 40 MHz clock
  mabs_tick_div #(.DIV(`MABS_DIV_COUNT)) u_div (
    .mclk_in   (mclk_in),
    .reset_n_in(reset_n_in),
    .run_in    (pwr_en_out),
    .tick_out  (tick)
  );

  function automatic logic [3:0] bit_idx(input logic [3:0] per);
    bit_idx = 4'(RES_BITS) - per;
  endfunction : bit_idx

  always_comb begin
    state_next  = state_reg;
    per_next    = per_reg;
    sar_next    = sar_reg;
    result_next = result_out;
    chan_next   = chan_sel_out;
    rchan_next  = result_chan_out;
    done_next   = 1'b0;
    // A press while busy is remembered until served; a press in the cycle of a clear is served by that conversion
    pend_next   = pend_reg | press;
    unique case (state_reg)
      mabs_pkg::MABS_ST_OFF: begin
        if (enable_in && (continuous_in || start_in || pend_next)) begin
          chan_next  = (pend_next && !start_in) ? `MABS_CH_BUTTON : vsense_sel_in;
          // A press that loses to start_in stays pending for the next conversion
          pend_next  = pend_next & start_in;
          per_next   = 4'h0;
          state_next = mabs_pkg::MABS_ST_WAKE;
        end
      end
      mabs_pkg::MABS_ST_WAKE: begin
        if (tick) begin
          per_next = per_reg + 4'h1;
          if (per_reg == 4'(`MABS_WAKE_PERIODS - 1)) begin
            per_next   = 4'h0;
            state_next = mabs_pkg::MABS_ST_SAMP;
          end
        end
      end
      mabs_pkg::MABS_ST_SAMP: begin
        if (tick) begin
          sar_next   = {1'b1, {(RES_BITS-1){1'b0}}};
          per_next   = 4'h1;
          state_next = mabs_pkg::MABS_ST_BITS;
        end
      end
      mabs_pkg::MABS_ST_BITS: begin
        if (tick) begin
          if (per_reg <= 4'(RES_BITS)) begin
            // Keep or drop the trial bit, then try the next lower one
            if (!sar_s2_reg) sar_next[bit_idx(per_reg)] = 1'b0;
            if (per_reg < 4'(RES_BITS)) sar_next[bit_idx(per_reg) - 4'h1] = 1'b1;
          end
          per_next = per_reg + 4'h1;
          if (per_reg == 4'(CONV_PER - 2)) begin
            state_next = mabs_pkg::MABS_ST_DONE;
          end
        end
      end
      mabs_pkg::MABS_ST_DONE: begin
        if (tick) begin
          result_next = sar_reg;
          rchan_next  = chan_sel_out;
          done_next   = 1'b1;
          per_next    = 4'h0;
          if (enable_in && continuous_in) begin
            chan_next  = pend_next ? `MABS_CH_BUTTON : vsense_sel_in;
            pend_next  = 1'b0;
            state_next = mabs_pkg::MABS_ST_SAMP;
          end else begin
            state_next = mabs_pkg::MABS_ST_OFF;
          end
        end
      end
      default: state_next = mabs_pkg::MABS_ST_OFF;
    endcase
  end

  // Tick gap counter, only trusted while the converter stays powered
  always_comb begin
    gap_next    = tick ? 16'h0000 : gap_reg + 16'h0001;
    gap_ok_next = pwr_en_out & (gap_ok_reg | tick);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_reg    <= 16'h0000;
      gap_ok_reg <= 1'b0;
    end else begin
      gap_reg    <= gap_next;
      gap_ok_reg <= gap_ok_next;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg       <= mabs_pkg::MABS_ST_OFF;
      per_reg         <= 4'h0;
      sar_reg         <= `MABS_RESULT_RESET;
      result_out      <= `MABS_RESULT_RESET;
      chan_sel_out    <= `MABS_CH_BUTTON;
      result_chan_out <= `MABS_CH_BUTTON;
      done_out        <= 1'b0;
      pend_reg        <= 1'b0;
      pwr_en_out      <= 1'b0;
      busy_out        <= 1'b0;
      conv_clk_en_out <= 1'b0;
      dac_code_out    <= `MABS_RESULT_RESET;
    end else begin
      state_reg       <= state_next;
      per_reg         <= per_next;
      sar_reg         <= sar_next;
      result_out      <= result_next;
      chan_sel_out    <= chan_next;
      result_chan_out <= rchan_next;
      done_out        <= done_next;
      pend_reg        <= pend_next;
      pwr_en_out      <= (state_next != mabs_pkg::MABS_ST_OFF);
      busy_out        <= (state_next != mabs_pkg::MABS_ST_OFF);
      conv_clk_en_out <= tick;
      dac_code_out    <= sar_next;
    end
  end

  AST_DONE_ONE_CYCLE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_out |=> !done_out) else $error("done pulse longer than one cycle");
  AST_DONE_HOLDS_RESULT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_out |-> result_out == $past(sar_reg)) else $error("result not taken from SAR");
  AST_POWER_OFF_AFTER: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_out && !$past(continuous_in) |-> !pwr_en_out) else $error("power not dropped");
  AST_TICK_SPACING: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    tick |=> !tick [*8]) else $error("converter clock too fast");
  AST_WAKE_ON_PRESS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_OFF && enable_in && press && !start_in
      |=> chan_sel_out == `MABS_CH_BUTTON && busy_out) else $error("press did not wake");
  AST_CHAN_STABLE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_BITS |=> $stable(chan_sel_out)) else $error("channel moved");
  AST_CONT_RESTART: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_DONE && tick && enable_in && continuous_in
      |=> state_reg == mabs_pkg::MABS_ST_SAMP) else $error("continuous did not restart");
  AST_BIT_COUNT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_BITS |-> per_reg <= 4'(CONV_PER - 2))
    else $error("too many bit periods");
  AST_TICK_PERIOD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    tick && gap_ok_reg |-> gap_reg == 16'(`MABS_DIV_COUNT - 1))
    else $error("converter clock period wrong");
  AST_FIRST_TRIAL: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_SAMP && tick
      |=> dac_code_out == {1'b1, {(RES_BITS-1){1'b0}}}) else $error("first trial not MSB");
  AST_POWER_TRACKS_STATE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    pwr_en_out == (state_reg != mabs_pkg::MABS_ST_OFF)) else $error("power out of step");
  AST_OFF_WHEN_DISABLED: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_reg == mabs_pkg::MABS_ST_OFF && !enable_in |=> state_reg == mabs_pkg::MABS_ST_OFF)
    else $error("woke while disabled");
  // A press during a conversion must not be lost
  AST_PRESS_KEPT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    press && (state_reg inside {mabs_pkg::MABS_ST_WAKE, mabs_pkg::MABS_ST_SAMP,
                                mabs_pkg::MABS_ST_BITS}) |=> pend_reg)
    else $error("press lost while busy");
endmodule : mabs_ctrl

// file: tb/monitor_adc_button_sense_bench.sv
// Self-checking bench for the monitor converter control block
`timescale 1ns/10ps
module monitor_adc_button_sense_bench;
  logic       mclk_in = 0, reset_n_in = 0, enable_in = 0, continuous_in = 0;
  logic       vsense_sel_in = 0, start_in = 0, button_cmp_in = 0;
  logic       sar_cmp_in, pwr_en_out, conv_clk_en_out, chan_sel_out;
  logic       result_chan_out, done_out, busy_out;
  logic [9:0] dac_code_out, result_out, vin = 10'h000;
  int         errors = 0, n_tests = 0, n, i;
  // Rows: channel, input level, expected result
  logic [20:0] rows [5] = '{{1'h0, 10'h000, 10'h000}, {1'h1, 10'h3ff, 10'h3ff},
                            {1'h0, 10'h200, 10'h200}, {1'h1, 10'h1ff, 10'h1ff},
                            {1'h0, 10'h155, 10'h155}};

  // Ideal analog side: keep the trial bit while the input is at or above it
  assign sar_cmp_in = (vin >= dac_code_out);
  always #12.5 mclk_in = ~mclk_in;

  mabs_ctrl i_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
    .continuous_in(continuous_in), .vsense_sel_in(vsense_sel_in), .start_in(start_in),
    .button_cmp_in(button_cmp_in), .sar_cmp_in(sar_cmp_in), .pwr_en_out(pwr_en_out),
    .conv_clk_en_out(conv_clk_en_out), .chan_sel_out(chan_sel_out),
    .dac_code_out(dac_code_out), .result_out(result_out),
    .result_chan_out(result_chan_out), .done_out(done_out), .busy_out(busy_out));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task step;
    @(posedge mclk_in);
    #1;
  endtask : step

  // Counts cycles until the done pulse, bounded
  task wait_done(output int cnt);
    cnt = 0;
    while (done_out !== 1'b1) begin
      step();
      cnt++;
      if (cnt > 4000) begin
        errors++;
        end_of_test();
      end
    end
  endtask : wait_done

  task wait_tick;
    int k;
    k = 0;
    while (conv_clk_en_out !== 1'b1) begin
      step();
      k++;
      if (k > 400) begin
        errors++;
        end_of_test();
      end
    end
  endtask : wait_tick

  initial begin
    step();
    check({pwr_en_out, busy_out, done_out, conv_clk_en_out}, 16'h0);
    check(result_out, 16'h0);
    repeat (4) step();
    reset_n_in = 1;
    enable_in = 1;
    for (i = 0; i < 5; i++) begin
      vsense_sel_in = rows[i][20];
      vin = rows[i][19:10];
      start_in = 1;
      step();
      start_in = 0;
      check({pwr_en_out, busy_out}, 16'h3);
      check(chan_sel_out, rows[i][20]);
      wait_done(n);
      check(result_out, rows[i][9:0]);
      check(result_chan_out, rows[i][20]);
      check(n >= 2600 && n <= 3200, 16'h1);
      step();
      check({done_out, pwr_en_out, result_out}, {6'h0, rows[i][9:0]});
    end
    // Tick spacing and a start ignored while busy
    vin = 10'h2aa;
    start_in = 1;
    step();
    start_in = 0;
    wait_tick();
    step();
    for (n = 1; n < 400 && conv_clk_en_out !== 1'b1; n++) step();
    check(n, 16'd200);
    step();
    wait_tick();
    check(dac_code_out, 16'h200);
    start_in = 1;
    step();
    start_in = 0;
    wait_done(n);
    check(result_out, 16'h2aa);
    repeat (3) step();
    check(busy_out, 16'h0);
    // Start while disabled is ignored
    enable_in = 0;
    start_in = 1;
    repeat (2) step();
    start_in = 0;
    check(busy_out, 16'h0);
    enable_in = 1;
    // Press on the button comparator wakes the converter on the button channel
    vsense_sel_in = 1;
    vin = 10'h0a5;
    button_cmp_in = 1;
    wait_done(n);
    button_cmp_in = 0;
    check({result_chan_out, result_out}, 16'h0a5);
    step();
    // A press during a voltage-sense conversion is served right after it
    vin = 10'h0f0;
    start_in = 1;
    step();
    start_in = 0;
    repeat (20) step();
    button_cmp_in = 1;
    wait_done(n);
    check({result_chan_out, result_out}, 16'h4f0);
    step();
    check(busy_out, 16'h1);
    wait_done(n);
    button_cmp_in = 0;
    check({result_chan_out, result_out}, 16'h0f0);
    step();
    // Continuous mode: one sample every 13 converter periods
    vsense_sel_in = 0;
    vin = 10'h31c;
    continuous_in = 1;
    wait_done(n);
    step();
    wait_done(n);
    check(n + 1, 16'd2600);
    check(result_out, 16'h31c);
    check(pwr_en_out, 16'h1);
    continuous_in = 0;
    step();
    wait_done(n);
    repeat (3) step();
    check(busy_out, 16'h0);
    // Reset in mid-conversion
    start_in = 1;
    step();
    start_in = 0;
    repeat (300) step();
    reset_n_in = 0;
    step();
    check({pwr_en_out, busy_out, done_out, conv_clk_en_out}, 16'h0);
    check(dac_code_out, 16'h0);
    reset_n_in = 1;
    step();
    check({pwr_en_out, busy_out, done_out, conv_clk_en_out}, 16'h0);
    check(result_out, 16'h0);
    start_in = 1;
    step();
    start_in = 0;
    check(busy_out, 16'h1);
    wait_done(n);
    check(result_out, 16'h31c);
    end_of_test();
  end
endmodule : monitor_adc_button_sense_bench
